// ==== hw/rps_pkg.sv ====
// Constants shared by the pin and watchdog reset sequencer.
// Assumes a single 25 MHz clock domain with an APB register slave.
package rps_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CAUSE_OFF  = 8'h00;
  localparam logic [7:0] REG_DEBUG_OFF  = 8'h04;
  localparam logic [7:0] REG_CTRL_OFF   = 8'h08;
  localparam logic [7:0] REG_STATUS_OFF = 8'h0C;
  localparam logic [7:0] REG_IRQ_ST_OFF = 8'h10;
  localparam logic [7:0] REG_IRQ_EN_OFF = 8'h14;
  localparam logic [7:0] REG_IRQ_CL_OFF = 8'h18;
  localparam logic [7:0] REG_RAM_OFF    = 8'h1C;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CAUSE_WDT_BIT   = 4;
  localparam logic [7:0]  CAUSE_PIN_VAL   = 8'h00;
  localparam logic [7:0]  DEBUG_PIN_VAL   = 8'h01;
  localparam int          DEBUG_SEL_BIT   = 0;
  localparam int          CTRL_WDT_RST_BIT = 0;
  localparam int          IRQ_PIN_BIT     = 0;
  localparam int          IRQ_WDT_BIT     = 1;
  localparam int          IRQ_RUN_BIT     = 2;
  localparam int          IRQ_DEBUG_BIT   = 3;
  localparam int          IRQ_WIDTH       = 4;
  localparam logic [31:0] WDT_CLEAR_VAL   = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ      = 25_000_000;
  localparam int STAB_EXP         = 16;
  localparam int STAB_CYCLES      = 2 ** STAB_EXP;
  localparam int WDT_HOLD_NS      = 2000;
  localparam int WDT_HOLD_CYCLES  = (WDT_HOLD_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int CPU_DIV          = 8;
  localparam int PERIPH_DIV_MAX   = 1024;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET,
    ST_STABILIZE,
    ST_RUN
  } rps_state_type;
endpackage : rps_pkg

// ==== hw/rps_sequencer.sv ====
// Pin and watchdog reset sequencer with APB register slave.
// Assumes the reset pin and debug reset input are asynchronous to clock_in,
// and that the watchdog request arrives on clock_in.
//
// How it works
// R1 - Low reset pin holds whole system reset.
// R2 - Pin rising edge releases pin reset.
// R3 - Enabled watchdog overflow forces full system reset.
// R4 - Watchdog reset lasts fixed time, self-releases.
// R5 - Main oscillator stopped in reset, restarts after.
// R6 - Divided peripheral clocks wait for stabilization.
// R7 - System and CPU clock restart at one eighth.
// R8 - CPU runs only after stabilization interval.
// R9 - Watchdog counter cleared in reset, restarts after.
// R10 - RAM contents kept across these resets.
// R11 - Port pins high impedance until software configures.
// R12 - Pin reset loads debug control with 01H.
// R13 - Watchdog reset keeps debug control register.
// R14 - Debug input high before bit clear enters debug.
// R15 - Other peripherals startable only after stabilization.
// R16 - Pin reset clears cause flags to zero.
// R17 - Watchdog reset sets cause bit four only.
// R18 - Stabilization counter starts at release, gates enables.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module rps_sequencer #(
  parameter int STAB_COUNT = rps_pkg::STAB_CYCLES,
  parameter int HOLD_COUNT = rps_pkg::WDT_HOLD_CYCLES
) (
  input  wire  logic        clock_in,
  input  wire  logic        rst_in,
  input  wire  logic        reset_pin_n_in,
  input  wire  logic        watchdog_reset_request_in,
  input  wire  logic        debug_reset_input_in,
  input  wire  logic        cpu_ram_access_in,
  input  wire  logic        psel_in,
  input  wire  logic        penable_in,
  input  wire  logic        pwrite_in,
  input  wire  logic [7:0]  paddr_in,
  input  wire  logic [31:0] pwdata_in,
  output logic [31:0]       prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  output logic              system_reset_out,
  output logic              main_osc_enable_out,
  output logic              periph_clock_enable_out,
  output logic              cpu_clock_enable_out,
  output logic              cpu_clock_div8_out,
  output logic              cpu_run_out,
  output logic              periph_start_enable_out,
  output logic              watchdog_clear_out,
  output logic              port_output_enable_out,
  output logic              ram_hold_out,
  output logic              debug_mode_out,
  output logic              irq_out
);
  import rps_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]    pin_sync_r;
  logic [2:0]    dbg_sync_r;
  logic          pin_level_r;
  logic          dbg_level_r;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_sync_r <= 3'h0;
      dbg_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], reset_pin_n_in};
      dbg_sync_r <= {dbg_sync_r[1:0], debug_reset_input_in};
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_level_r <= 1'b0;
      dbg_level_r <= 1'b0;
    end else begin
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_level_r <= pin_sync_r[2];
      end
      if (dbg_sync_r[1] == dbg_sync_r[2]) begin
        dbg_level_r <= dbg_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]           cause_r;
  logic [7:0]           debug_ctrl_r;
  logic                 wdt_reset_mode_r;
  logic                 port_cfg_r;
  logic [IRQ_WIDTH-1:0] irq_status_r;
  logic [IRQ_WIDTH-1:0] irq_enable_r;
  logic                 ram_invalid_r;

  logic                 wr_en;
  logic                 rd_en;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rps_state_type state_r;
  logic [31:0]   stab_cnt_r;
  logic [31:0]   hold_cnt_r;
  logic          wdt_active_r;
  logic          wdt_trigger;
  logic          pin_low;

  assign pin_low     = !pin_level_r;
  assign wdt_trigger = watchdog_reset_request_in && wdt_reset_mode_r
                       && state_r != ST_RESET; // R3

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r      <= ST_RESET;
      stab_cnt_r   <= 32'h0000_0000;
      hold_cnt_r   <= 32'h0000_0000;
      wdt_active_r <= 1'b0;
    end else if (pin_low) begin
      state_r      <= ST_RESET; // R1
      stab_cnt_r   <= 32'h0000_0000;
      wdt_active_r <= 1'b0;
    end else if (wdt_trigger) begin
      state_r      <= ST_RESET; // R3
      hold_cnt_r   <= 32'h0000_0000;
      wdt_active_r <= 1'b1;
    end else begin
      case (state_r)
        ST_RESET: begin
          if (!wdt_active_r) begin
            state_r    <= ST_STABILIZE; // R2
            stab_cnt_r <= 32'h0000_0000;
          end else if (hold_cnt_r == 32'(HOLD_COUNT - 1)) begin
            state_r      <= ST_STABILIZE; // R4
            stab_cnt_r   <= 32'h0000_0000;
            wdt_active_r <= 1'b0;
          end else begin
            hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
          end
        end
        ST_STABILIZE: begin
          if (stab_cnt_r == 32'(STAB_COUNT - 1)) begin
            state_r <= ST_RUN; // R18
          end else begin
            stab_cnt_r <= stab_cnt_r + 32'h0000_0001;
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock, CPU and port outputs
  // ----------------------------------------------------------------
  logic in_reset_nxt;
  logic run_nxt;
  assign in_reset_nxt = pin_low || wdt_trigger || (state_r == ST_RESET &&
                        !(wdt_active_r ? hold_cnt_r == 32'(HOLD_COUNT - 1) : 1'b1));
  assign run_nxt = !pin_low && !wdt_trigger &&
                   (state_r == ST_RUN ||
                    (state_r == ST_STABILIZE && stab_cnt_r == 32'(STAB_COUNT - 1)));

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      system_reset_out        <= 1'b1;
      main_osc_enable_out     <= 1'b0;
      periph_clock_enable_out <= 1'b0;
      cpu_clock_enable_out    <= 1'b0;
      cpu_clock_div8_out      <= 1'b1;
      cpu_run_out             <= 1'b0;
      periph_start_enable_out <= 1'b0;
      watchdog_clear_out      <= 1'b1;
    end else begin
      system_reset_out        <= in_reset_nxt; // R1
      main_osc_enable_out     <= !in_reset_nxt; // R5
      periph_clock_enable_out <= run_nxt; // R6
      cpu_clock_enable_out    <= run_nxt; // R7
      cpu_run_out             <= run_nxt; // R8
      periph_start_enable_out <= run_nxt; // R15
      watchdog_clear_out      <= in_reset_nxt; // R9
      if (in_reset_nxt) begin
        cpu_clock_div8_out <= 1'b1; // R7
      end else begin
        cpu_clock_div8_out <= cpu_clock_div8_out;
      end
    end
  end

  // Ports stay released until software sets the port configure bit.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      port_cfg_r             <= 1'b0;
      port_output_enable_out <= 1'b0;
    end else if (in_reset_nxt) begin
      port_cfg_r             <= 1'b0; // R11
      port_output_enable_out <= 1'b0;
    end else begin
      if (wr_en && addr_hit(paddr_in, REG_CTRL_OFF)) begin
        port_cfg_r <= pwdata_in[1];
      end
      port_output_enable_out <= port_cfg_r && run_nxt; // R11
    end
  end

  // RAM is kept; a CPU access that collides with reset entry marks it damaged.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ram_invalid_r <= 1'b1;
      ram_hold_out  <= 1'b0;
    end else begin
      ram_hold_out <= in_reset_nxt; // R10
      if ((pin_low || wdt_trigger) && !system_reset_out && cpu_ram_access_in) begin
        ram_invalid_r <= 1'b1; // R10
      end else if (wr_en && addr_hit(paddr_in, REG_RAM_OFF) && pwdata_in[0]) begin
        ram_invalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cause flags, debug control and watchdog mode
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cause_r <= CAUSE_PIN_VAL;
    end else if (pin_low) begin
      cause_r <= CAUSE_PIN_VAL; // R16
    end else if (wdt_trigger) begin
      cause_r[CAUSE_WDT_BIT] <= 1'b1; // R17
    end else if (wr_en && addr_hit(paddr_in, REG_CAUSE_OFF)) begin
      cause_r <= pwdata_in[7:0] & cause_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || pin_low) begin
      debug_ctrl_r <= DEBUG_PIN_VAL; // R12
    end else if (wr_en && addr_hit(paddr_in, REG_DEBUG_OFF)) begin
      debug_ctrl_r <= pwdata_in[7:0]; // R13
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || in_reset_nxt) begin
      wdt_reset_mode_r <= 1'b1;
      debug_mode_out   <= 1'b0;
    end else begin
      if (wr_en && addr_hit(paddr_in, REG_CTRL_OFF)) begin
        wdt_reset_mode_r <= pwdata_in[CTRL_WDT_RST_BIT];
      end
      if (dbg_level_r && debug_ctrl_r[DEBUG_SEL_BIT]) begin
        debug_mode_out <= 1'b1; // R14
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irq_set;
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_PIN_BIT]   = pin_low && !system_reset_out;
    irq_set[IRQ_WDT_BIT]   = wdt_trigger;
    irq_set[IRQ_RUN_BIT]   = run_nxt && !cpu_run_out;
    irq_set[IRQ_DEBUG_BIT] = dbg_level_r && debug_ctrl_r[DEBUG_SEL_BIT] && !debug_mode_out;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_status_r <= '0;
      irq_enable_r <= '0;
      irq_out      <= 1'b0;
    end else begin
      if (wr_en && addr_hit(paddr_in, REG_IRQ_CL_OFF)) begin
        irq_status_r <= (irq_status_r & ~pwdata_in[IRQ_WIDTH-1:0]) | irq_set;
      end else begin
        irq_status_r <= irq_status_r | irq_set;
      end
      if (wr_en && addr_hit(paddr_in, REG_IRQ_EN_OFF)) begin
        irq_enable_r <= pwdata_in[IRQ_WIDTH-1:0];
      end
      irq_out <= |(irq_status_r & irq_enable_r);
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic        rd_err;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr_in)
      REG_CAUSE_OFF:  rd_data = {24'h00_0000, cause_r};
      REG_DEBUG_OFF:  rd_data = {24'h00_0000, debug_ctrl_r};
      REG_CTRL_OFF:   rd_data = {30'h0000_0000, port_cfg_r, wdt_reset_mode_r};
      REG_STATUS_OFF: rd_data = {28'h000_0000, debug_mode_out, cpu_run_out,
                                 system_reset_out, pin_level_r};
      REG_IRQ_ST_OFF: rd_data = {28'h000_0000, irq_status_r};
      REG_IRQ_EN_OFF: rd_data = {28'h000_0000, irq_enable_r};
      REG_IRQ_CL_OFF: rd_data = 32'h0000_0000;
      REG_RAM_OFF:    rd_data = {31'h0000_0000, ram_invalid_r};
      default:        rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && rd_err;
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= rd_data;
      end else if (rd_en) begin
        prdata_out <= prdata_out;
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

endmodule // rps_sequencer

// ==== bench/rps_sequencer_sva.sv ====
// Concurrent checks on the ports of the reset sequencer.
// Assumes binding onto rps_sequencer with its stabilization count handed on.
`timescale 1ns/1ns
module rps_sequencer_chk #(
  parameter int STAB_COUNT = 16
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic system_reset_out,
  input wire logic main_osc_enable_out,
  input wire logic periph_clock_enable_out,
  input wire logic cpu_clock_enable_out,
  input wire logic cpu_clock_div8_out,
  input wire logic cpu_run_out,
  input wire logic periph_start_enable_out,
  input wire logic watchdog_clear_out,
  input wire logic port_output_enable_out,
  input wire logic debug_mode_out
);
  logic [15:0] stab_cnt_r;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Counts cycles out of reset with the CPU still held.
  always_ff @(posedge clock_in) begin
    if (rst_in || system_reset_out) begin
      stab_cnt_r <= 16'h0000;
    end else if (!cpu_run_out && stab_cnt_r != 16'hFFFF) begin
      stab_cnt_r <= stab_cnt_r + 16'h0001;
    end
  end
  chk_pin_holds_reset: assert property (!reset_pin_n_in [*6] |-> system_reset_out)
    else $error("pin low without system reset");
  chk_clocks_stopped: assert property (system_reset_out |-> !main_osc_enable_out
    && !periph_clock_enable_out && !cpu_clock_enable_out) else $error("clock running in reset");
  chk_osc_restart: assert property ($fell(system_reset_out) |-> ##[0:2] main_osc_enable_out)
    else $error("oscillator not restarted");
  chk_run_gated: assert property (cpu_run_out |-> cpu_clock_enable_out
    && periph_clock_enable_out && !system_reset_out) else $error("cpu runs without clocks");
  chk_periph_start: assert property (periph_start_enable_out |-> !system_reset_out
    && main_osc_enable_out) else $error("peripherals startable too early");
  chk_stab_count: assert property ($rose(cpu_run_out) |-> stab_cnt_r >= STAB_COUNT - 1)
    else $error("stabilization interval cut short");
  chk_div8_start: assert property ($rose(cpu_clock_enable_out) |-> cpu_clock_div8_out)
    else $error("cpu clock not at one eighth");
  chk_wdt_cleared: assert property (system_reset_out |-> watchdog_clear_out)
    else $error("watchdog not cleared in reset");
  chk_wdt_restart: assert property ($fell(system_reset_out) |-> ##[0:2] !watchdog_clear_out)
    else $error("watchdog not restarted");
  chk_ports_hiz: assert property (system_reset_out [*2] |-> !port_output_enable_out)
    else $error("port driven in reset");
  chk_wdt_release: assert property (($rose(system_reset_out) && reset_pin_n_in)
    ##1 reset_pin_n_in [*8] |-> ##[0:4] !system_reset_out) else $error("reset not released");
  chk_debug_cleared: assert property (system_reset_out [*2] |-> !debug_mode_out)
    else $error("debug mode kept through reset");
  cover property ($rose(cpu_run_out));
  cover property ($rose(system_reset_out) && reset_pin_n_in);
  cover property ($rose(debug_mode_out));
endmodule // rps_sequencer_chk
bind rps_sequencer rps_sequencer_chk #(.STAB_COUNT(STAB_COUNT)) i_chk (.clock_in, .rst_in,
  .reset_pin_n_in, .system_reset_out, .main_osc_enable_out, .periph_clock_enable_out,
  .cpu_clock_enable_out, .cpu_clock_div8_out, .cpu_run_out, .periph_start_enable_out,
  .watchdog_clear_out, .port_output_enable_out, .debug_mode_out);

// ==== bench/rps_partner.sv ====
// Far side model: external reset pin driver and a periodic watchdog.
// Assumes the bench calls set_pin right after a rising clock edge.
`timescale 1ns/1ns
module rps_partner #(
  parameter int WDT_LIMIT = 40
) (
  input  wire logic clock_in,
  input  wire logic wdt_clear_in,
  input  wire logic wdt_arm_in,
  output logic      pin_n_out,
  output logic      wdt_req_out
);
  logic [7:0] wdt_count_r = 8'h00;
  initial pin_n_out = 1'b0;
  // The count stays at zero while the sequencer holds it cleared.
  always_ff @(posedge clock_in) begin
    if (wdt_clear_in || !wdt_arm_in || wdt_req_out) begin
      wdt_count_r <= 8'h00;
    end else begin
      wdt_count_r <= wdt_count_r + 8'h01;
    end
  end
  assign wdt_req_out = (wdt_count_r == 8'(WDT_LIMIT));
  task automatic set_pin(input logic level);
    pin_n_out <= level;
  endtask
endmodule // rps_partner

// ==== bench/rps_sequencer_tb.sv ====
// Self-checking bench for the reset sequencer.
// Assumes the partner model drives the reset pin and the watchdog request.
`timescale 1ns/1ns
module rps_sequencer_tb;
  import rps_pkg::*;
  localparam int STAB = 16;
  logic clock_in, rst_in, reset_pin_n_in, watchdog_reset_request_in, pready_out, pslverr_out;
  logic debug_reset_input_in = 1'b0, cpu_ram_access_in = 1'b0, wdt_arm = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic system_reset_out, main_osc_enable_out, periph_clock_enable_out, cpu_clock_enable_out;
  logic cpu_clock_div8_out, cpu_run_out, periph_start_enable_out, watchdog_clear_out;
  logic port_output_enable_out, ram_hold_out, debug_mode_out, irq_out;
  int mismatches = 0;
  int compares = 0;
  rps_sequencer #(.STAB_COUNT(STAB), .HOLD_COUNT(4)) i_dut (.clock_in, .rst_in,
    .reset_pin_n_in, .watchdog_reset_request_in, .debug_reset_input_in, .cpu_ram_access_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .system_reset_out, .main_osc_enable_out, .periph_clock_enable_out,
    .cpu_clock_enable_out, .cpu_clock_div8_out, .cpu_run_out, .periph_start_enable_out,
    .watchdog_clear_out, .port_output_enable_out, .ram_hold_out, .debug_mode_out, .irq_out);
  rps_partner i_far (.clock_in, .wdt_clear_in(watchdog_clear_out), .wdt_arm_in(wdt_arm),
    .pin_n_out(reset_pin_n_in), .wdt_req_out(watchdog_reset_request_in));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= wd;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(nm, rd, exp);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (system_reset_out !== 1'b0) begin
      @(posedge clock_in);
    end
    while (cpu_run_out !== 1'b1 && n < 200) begin
      @(posedge clock_in);
      n++;
    end
    chk("stab_wait", 32'(n >= STAB - 1 && n < 200), 32'h1);
    chk("on_clocks", {main_osc_enable_out, periph_clock_enable_out, cpu_clock_enable_out,
      cpu_clock_div8_out, periph_start_enable_out, watchdog_clear_out, ram_hold_out},
      32'h7C);
  endtask
  task automatic test_pin(input logic collide);
    cpu_ram_access_in <= collide;
    i_far.set_pin(1'b0);
    repeat (10) @(posedge clock_in);
    chk("in_reset", {system_reset_out, watchdog_clear_out, main_osc_enable_out,
      ram_hold_out}, 32'hD);
    chk("held", {cpu_run_out, periph_start_enable_out, port_output_enable_out}, 32'h0);
    cpu_ram_access_in <= 1'b0;
    i_far.set_pin(1'b1);
    wait_run();
    rdc("cause", REG_CAUSE_OFF, 32'(CAUSE_PIN_VAL));
    rdc("debug", REG_DEBUG_OFF, 32'(DEBUG_PIN_VAL));
    rdc("ram_bad", REG_RAM_OFF, 32'h1);
    $display("test pin reset done");
  endtask
  task automatic test_regs();
    logic [31:0] rd;
    logic e;
    rdc("ctrl", REG_CTRL_OFF, 32'h1);
    wr(REG_CTRL_OFF, 32'h3);
    apb(1'b0, 8'h40, 32'h0, rd, e);
    chk("slverr", {31'h0000_0000, e}, 32'h0000_0001);
    chk("slverr_data", rd, 32'h0000_0000);
    chk("port_oe", port_output_enable_out, 32'h1);
    wr(REG_IRQ_EN_OFF, 32'h0);
    rdc("irq_st", REG_IRQ_ST_OFF, 32'h4);
    chk("irq_masked", irq_out, 32'h0);
    wr(REG_IRQ_EN_OFF, 32'h4);
    repeat (3) @(posedge clock_in);
    chk("irq_on", irq_out, 32'h1);
    wr(REG_IRQ_CL_OFF, 32'h4);
    repeat (3) @(posedge clock_in);
    chk("irq_off", irq_out, 32'h0);
    wr(REG_RAM_OFF, 32'h1);
    rdc("ram_ok", REG_RAM_OFF, 32'h0);
    $display("test registers done");
  endtask
  task automatic test_wdt();
    int n;
    wr(REG_DEBUG_OFF, 32'h0);
    wr(REG_CTRL_OFF, 32'h2);
    wdt_arm <= 1'b1;
    repeat (100) @(posedge clock_in);
    chk("wdt_off", system_reset_out, 32'h0);
    wr(REG_CTRL_OFF, 32'h3);
    for (n = 0; n < 100 && system_reset_out !== 1'b1; n++) @(posedge clock_in);
    wdt_arm <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk("wdt_rst", {system_reset_out, port_output_enable_out}, 32'h2);
    wait_run();
    rdc("cause", REG_CAUSE_OFF, 32'(1 << CAUSE_WDT_BIT));
    rdc("debug", REG_DEBUG_OFF, 32'h0);
    rdc("ram_kept", REG_RAM_OFF, 32'h0);
    debug_reset_input_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    chk("no_debug", debug_mode_out, 32'h0);
    debug_reset_input_in <= 1'b0;
    $display("test watchdog reset done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    mismatches++;
    end_sim();
  end
  initial begin
    rst_in = 1'b1;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    test_pin(1'b0);
    test_regs();
    test_wdt();
    test_pin(1'b1);
    debug_reset_input_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    chk("debug_mode", debug_mode_out, 32'h1);
    $display("test debug entry done");
    end_sim();
  end
endmodule // rps_sequencer_tb
